// File: rtl/kwu_defs.svh
`ifndef KWU_DEFS_SVH
`define KWU_DEFS_SVH

// register indices; byte address is four times the index
`define KWU_IDX_CTRL_LOW   14'h0fc4
`define KWU_IDX_CTRL_HIGH  14'h0fc5
`define KWU_IDX_SYS_CTRL   14'h0fc6
`define KWU_IDX_PULLUP     14'h0fc7
`define KWU_IDX_EVT_STAT   14'h0fc8
`define KWU_IDX_EVT_MASK   14'h0fc9
`define KWU_IDX_LIVE       14'h0fca

// reset values
`define KWU_RST_CTRL       8'h00
`define KWU_RST_SYS        2'h0
`define KWU_RST_PULLUP     8'h00
`define KWU_RST_EVT        2'h0

// system control fields
`define KWU_SYS_STOP_BIT   0
`define KWU_SYS_RELM_BIT   1

// event status fields
`define KWU_EVT_WAKE_BIT   0
`define KWU_EVT_SKIP_BIT   1

// warm-up after release
`define KWU_CLK_PERIOD_NS  25
`define KWU_WARMUP_NS      1000
`define KWU_WARMUP_CYC \
  ((`KWU_WARMUP_NS + `KWU_CLK_PERIOD_NS - 1) / `KWU_CLK_PERIOD_NS)

`endif

// File: rtl/kwu_pkg.sv
package kwu_pkg;
  typedef enum logic [1:0] {
    st_run  = 2'h0,
    st_stop = 2'h1,
    st_warm = 2'h3
  } kwu_state_t;
endpackage

// File: rtl/kwu_key_cell.sv
module kwu_key_cell #(
  parameter bit INVERT_PIN = 1'b0
) (
  input  wire logic enable,
  input  wire logic level_high,
  input  wire logic pin,
  output logic      at_level
);
  wire pin_seen = pin ^ INVERT_PIN;

  assign at_level = enable & (pin_seen == level_high);
endmodule

// File: rtl/kwu_wakeup.sv
// The implementer's own choice: register access over APB.
`include "kwu_defs.svh"

// Notes on behaviour
// - per key enable makes it a source
// - level bit picks low or high release
// - two byte registers, enable even, level odd
// - reset clears all key bits
// - stop pin always releases in level mode, no disable; in edge mode only a rise with no key at level
// - level mode releases on pin high or key level
// - edge mode uses stop pin rising edge
// - source already active skips stop entry
// - pull-up bit enables key pull-up
module kwu_wakeup #(
  parameter int NKEYS = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [15:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NKEYS-1:0]  key_wake_input,
  input  wire logic              stop_release_pin,
  output logic      [NKEYS-1:0]  pullup_enable,
  output logic                   release_request,
  output logic                   stop_active,
  output kwu_pkg::kwu_state_t    stop_state,
  output logic                   irq
);
  import kwu_pkg::*;

  localparam int WARM_D = `KWU_WARMUP_CYC;
  localparam logic [7:0] WARM_CNT = 8'(WARM_D - 1);

  // registers
  logic [7:0]       key_wake_ctrl_low;
  logic [7:0]       key_wake_ctrl_high;
  logic [1:0]       system_control_one;
  logic [7:0]       port_pullup_control;
  logic [1:0]       evt_status;
  logic [1:0]       evt_mask;
  logic             stop_pin_q;
  logic [7:0]       warm_cnt;
  kwu_state_t       state;
  kwu_state_t       next_state;

  // address decode
  wire [15:0] a_ctrl_low  = {`KWU_IDX_CTRL_LOW, 2'b00};
  wire [15:0] a_ctrl_high = {`KWU_IDX_CTRL_HIGH, 2'b00};
  wire [15:0] a_sys       = {`KWU_IDX_SYS_CTRL, 2'b00};
  wire [15:0] a_pullup    = {`KWU_IDX_PULLUP, 2'b00};
  wire [15:0] a_evt_stat  = {`KWU_IDX_EVT_STAT, 2'b00};
  wire [15:0] a_evt_mask  = {`KWU_IDX_EVT_MASK, 2'b00};
  wire [15:0] a_live      = {`KWU_IDX_LIVE, 2'b00};

  wire sel_ctrl_low  = (paddr == a_ctrl_low);
  wire sel_ctrl_high = (paddr == a_ctrl_high);
  wire sel_sys       = (paddr == a_sys);
  wire sel_pullup    = (paddr == a_pullup);
  wire sel_evt_stat  = (paddr == a_evt_stat);
  wire sel_evt_mask  = (paddr == a_evt_mask);
  wire sel_live      = (paddr == a_live);
  wire mapped = sel_ctrl_low | sel_ctrl_high | sel_sys | sel_pullup |
                sel_evt_stat | sel_evt_mask | sel_live;

  wire access = psel & penable;
  wire wr_en  = access & pwrite & mapped & pstrb[0];
  wire rd_en  = access & ~pwrite;
  wire [7:0] wdata_low = pwdata[7:0];

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // key release evaluation
  // enable even, level odd
  wire [15:0] key_cfg = {key_wake_ctrl_high, key_wake_ctrl_low};
  logic [NKEYS-1:0] key_at_level;

  genvar k;
  generate
    for (k = 0; k < NKEYS; k++) begin : g_key
      kwu_key_cell #(
        .INVERT_PIN (1'b0)
      ) u_cell (
        .enable     (key_cfg[2*k]),
        .level_high (key_cfg[2*k+1]),
        .pin        (key_wake_input[k]),
        .at_level   (key_at_level[k])
      );
    end
  endgenerate

  wire key_any    = |key_at_level;
  wire level_mode = system_control_one[`KWU_SYS_RELM_BIT];
  wire stop_rise  = stop_release_pin & ~stop_pin_q;

  wire level_release = stop_release_pin | key_any;
  wire edge_release  = stop_rise & ~key_any;

  assign release_request = level_mode ? level_release : edge_release;

  // stop entry request
  // stop bit written by software
  wire stop_req = wr_en & sel_sys & (state == st_run) &
                  pwdata[`KWU_SYS_STOP_BIT];
  wire skip_entry = stop_req & level_release;

  assign stop_active = (state == st_stop);
  assign stop_state  = state;

  // state machine
  always_comb begin
    next_state = state;
    case (state)
      st_run: begin
        if (stop_req && !skip_entry) begin
          next_state = st_stop;
        end
      end
      st_stop: begin
        if (release_request) begin
          next_state = st_warm;
        end
      end
      st_warm: begin
        if (warm_cnt == 8'h00) begin
          next_state = st_run;
        end
      end
      default: begin
        next_state = st_run;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_run;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_cnt <= 8'h00;
    end else if (state == st_stop) begin
      warm_cnt <= WARM_CNT;
    end else if (warm_cnt != 8'h00) begin
      warm_cnt <= warm_cnt - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_pin_q <= 1'b0;
    end else begin
      stop_pin_q <= stop_release_pin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_wake_ctrl_low  <= `KWU_RST_CTRL;
      key_wake_ctrl_high <= `KWU_RST_CTRL;
    end else if (wr_en && sel_ctrl_low) begin
      key_wake_ctrl_low  <= pwdata[7:0];
    end else if (wr_en && sel_ctrl_high) begin
      key_wake_ctrl_high <= pwdata[7:0];
    end
  end

  // stop bit is a command; only the mode bit is stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_control_one <= `KWU_RST_SYS;
    end else if (wr_en && sel_sys) begin
      system_control_one[`KWU_SYS_RELM_BIT] <=
        pwdata[`KWU_SYS_RELM_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_pullup_control <= `KWU_RST_PULLUP;
    end else if (wr_en && sel_pullup) begin
      port_pullup_control <= pwdata[7:0];
    end
  end
  assign pullup_enable = port_pullup_control[NKEYS-1:0];

  // events; a new event wins over the read clear
  wire       wake_evt = (state == st_warm) && (warm_cnt == 8'h00);
  wire [1:0] evt_set  = {skip_entry, wake_evt};
  wire       evt_clr  = rd_en & sel_evt_stat;
  // clear only what the read returned; a bit set at setup survives
  wire [1:0] evt_clr_bits = evt_clr ? prdata[1:0] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status <= `KWU_RST_EVT;
    end else begin
      evt_status <= (evt_status & ~evt_clr_bits) | evt_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask <= `KWU_RST_EVT;
    end else if (wr_en && sel_evt_mask) begin
      evt_mask <= pwdata[1:0];
    end
  end

  assign irq = |(evt_status & evt_mask);

  // read mux
  wire stop_busy = (state != st_run);
  wire [31:0] sys_rd  = {30'h0, level_mode, stop_busy};
  wire [31:0] live_rd = {11'h0, release_request, key_any,
                         stop_release_pin, key_at_level, key_wake_input,
                         state};
  wire [31:0] rd_mux =
    sel_ctrl_low  ? {24'h0, key_wake_ctrl_low}   :
    sel_ctrl_high ? {24'h0, key_wake_ctrl_high}  :
    sel_sys       ? sys_rd                       :
    sel_pullup    ? {24'h0, port_pullup_control} :
    sel_evt_stat  ? {30'h0, evt_status}          :
    sel_evt_mask  ? {30'h0, evt_mask}            :
    sel_live      ? live_rd                      :
                    32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_key_disabled: assert property (
    (key_cfg == 16'h0) |-> !key_any)
    else $error("disabled keys produced a release");

  a_level_select: assert property (
    (key_cfg[0] && key_cfg[1] == key_wake_input[0]) |-> key_any)
    else $error("key at level gave no release");

  a_ctrl_reset: assert property (
    $rose(presetn) |-> (key_cfg == 16'h0))
    else $error("key control not clear after reset");

  a_pin_always: assert property (
    (level_mode && stop_release_pin) |-> release_request)
    else $error("stop pin ignored in level mode");

  a_edge_mode: assert property (
    (!level_mode && !stop_pin_q && stop_release_pin && !key_any)
    |-> release_request)
    else $error("rising edge missed in edge mode");

  a_edge_blocked: assert property (
    (!level_mode && key_any) |-> !release_request)
    else $error("edge release despite active key");

  a_skip_entry: assert property (
    skip_entry |=> (state == st_run) && evt_status[`KWU_EVT_SKIP_BIT])
    else $error("stop entered while source active");

  a_enter_stop: assert property (
    (stop_req && !level_release) |=> (state == st_stop))
    else $error("stop not entered on request");

  a_warm_len: assert property (
    (stop_active && release_request) |=> (state == st_warm)
    ##[WARM_D:WARM_D] (state == st_run))
    else $error("warm-up length wrong");

  a_irq_level: assert property (
    wake_evt && evt_mask[`KWU_EVT_WAKE_BIT] |=> irq)
    else $error("unmasked wake event gave no interrupt");

  a_pullup_write: assert property (
    (wr_en && sel_pullup) |=> (pullup_enable == $past(wdata_low)))
    else $error("pull-up write not applied");

  a_level_wrong: assert property (
    ((key_cfg == 16'h0001) && key_wake_input[0]) |-> !key_any)
    else $error("key off its release level gave a release");

  a_low_reg_map: assert property (
    (key_wake_ctrl_low[2] && (key_wake_ctrl_low[3] == key_wake_input[1]))
    |-> key_any)
    else $error("key one bits not at positions two and three");

  a_high_reg_map: assert property (
    (key_wake_ctrl_high[6] && (key_wake_ctrl_high[7] == key_wake_input[7]))
    |-> key_any)
    else $error("key seven bits not at top of high register");

  a_ctrl_write: assert property (
    (wr_en && sel_ctrl_low) |=> (key_wake_ctrl_low == $past(wdata_low)))
    else $error("key control write not applied");

  a_reset_state: assert property (
    $rose(presetn) |-> ((state == st_run) && !irq))
    else $error("not idle after reset");

  a_no_source: assert property (
    (level_mode && !stop_release_pin && (key_cfg == 16'h0))
    |-> !release_request)
    else $error("release without any source");

  a_stop_hold: assert property (
    (stop_active && !release_request) |=> stop_active)
    else $error("stop left without release");

  a_wake_status: assert property (
    wake_evt |=> evt_status[`KWU_EVT_WAKE_BIT])
    else $error("wake event not recorded");

  a_key_release: assert property (
    (stop_active && level_mode && key_any) |-> release_request)
    else $error("key at level gave no release in stop");

  a_edge_steady: assert property (
    (!level_mode && stop_pin_q) |-> !release_request)
    else $error("steady high pin released in edge mode");
endmodule

// File: bench/kwu_key_partner.sv
module kwu_key_partner (
  input  wire logic       pclk,
  input  wire logic [7:0] key_level,
  input  wire logic [7:0] key_driven,
  input  wire logic       pin_level,
  input  wire logic [7:0] pullup_enable,
  output logic      [7:0] key_wake_input,
  output logic            stop_release_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // undriven key without pull-up keeps changing, never a steady guess
  logic [7:0] float_pat = 8'h00;
  always @(posedge pclk) float_pat <= ~float_pat;
  // pull-up holds a released key high
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      key_wake_input[k] = key_driven[k] ? key_level[k] :
                          (pullup_enable[k] ? 1'b1 : float_pat[k]);
    end
  end
  // pin low unless bench raises it
  assign stop_release_pin = pin_level;
endmodule

// File: bench/kwu_wakeup_bench.sv
`include "kwu_defs.svh"
module kwu_wakeup_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import kwu_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  key_level = 8'h00;
  logic [7:0]  key_driven = 8'hff;
  logic        pin_level = 1'b0;
  logic [7:0]  key_wake_input;
  logic        stop_release_pin;
  logic [7:0]  pullup_enable;
  logic        release_request;
  logic        stop_active;
  kwu_state_t  stop_state;
  logic        irq;
  logic [31:0] r;
  logic        e;
  logic [15:0] cfg;
  int          n;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #12.5 pclk = ~pclk;
  kwu_wakeup u_kwu_wakeup (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_wake_input(key_wake_input), .stop_release_pin(stop_release_pin),
    .pullup_enable(pullup_enable), .release_request(release_request),
    .stop_active(stop_active), .stop_state(stop_state), .irq(irq));
  kwu_key_partner u_kwu_key_partner (.pclk(pclk), .key_level(key_level),
    .key_driven(key_driven), .pin_level(pin_level),
    .pullup_enable(pullup_enable), .key_wake_input(key_wake_input),
    .stop_release_pin(stop_release_pin));
  task automatic conclude();
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [13:0] idx,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [13:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(r, exp);
  endtask
  task automatic st();
    repeat (2) @(negedge pclk);
    @(posedge pclk);
  endtask
  task automatic wait_st(input kwu_state_t s);
    n = 0;
    while (stop_state !== s && n < 200) begin
      @(negedge pclk);
      n++;
    end
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`KWU_IDX_CTRL_LOW, 32'h0);
    rdc(`KWU_IDX_CTRL_HIGH, 32'h0);
    rdc(`KWU_IDX_PULLUP, 32'h0);
    apb(1'b0, 14'h0100, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, `KWU_IDX_CTRL_LOW, 32'h5a);
    apb(1'b1, `KWU_IDX_CTRL_HIGH, 32'ha5);
    rdc(`KWU_IDX_CTRL_LOW, 32'h5a);
    rdc(`KWU_IDX_CTRL_HIGH, 32'ha5);
    apb(1'b1, `KWU_IDX_SYS_CTRL, 32'h2);
    rdc(`KWU_IDX_SYS_CTRL, 32'h2);
    for (int k = 0; k < 8; k++) begin
      for (int l = 0; l < 2; l++) begin
        cfg = (16'h1 << (2 * k)) | (16'(l) << (2 * k + 1));
        apb(1'b1, `KWU_IDX_CTRL_LOW, {24'h0, cfg[7:0] & 8'h55});
        apb(1'b1, `KWU_IDX_CTRL_HIGH, {24'h0, cfg[15:8] & 8'h55});
        apb(1'b1, `KWU_IDX_CTRL_LOW, {24'h0, cfg[7:0]});
        apb(1'b1, `KWU_IDX_CTRL_HIGH, {24'h0, cfg[15:8]});
        key_level <= {8{~l[0]}};
        st();
        chk({31'h0, release_request}, 32'h0);
        key_level <= {8{l[0]}};
        st();
        chk({31'h0, release_request}, 32'h1);
        cfg = cfg & ~(16'h1 << (2 * k));
        apb(1'b1, `KWU_IDX_CTRL_LOW, {24'h0, cfg[7:0]});
        apb(1'b1, `KWU_IDX_CTRL_HIGH, {24'h0, cfg[15:8]});
        st();
        chk({31'h0, release_request}, 32'h0);
      end
    end
    apb(1'b1, `KWU_IDX_CTRL_LOW, 32'h0);
    apb(1'b1, `KWU_IDX_CTRL_HIGH, 32'h0);
    apb(1'b1, `KWU_IDX_EVT_MASK, 32'h3);
    pin_level <= 1'b1;
    st();
    chk({31'h0, release_request}, 32'h1);
    rdc(`KWU_IDX_LIVE, 32'h0014_03fc);
    apb(1'b1, `KWU_IDX_SYS_CTRL, 32'h3);
    st();
    chk(32'(stop_state), 32'(st_run));
    chk({31'h0, irq}, 32'h1);
    rdc(`KWU_IDX_EVT_STAT, 32'h2);
    st();
    chk({31'h0, irq}, 32'h0);
    pin_level <= 1'b0;
    apb(1'b1, `KWU_IDX_PULLUP, 32'h1);
    st();
    chk({24'h0, pullup_enable}, 32'h1);
    key_driven <= 8'hfe;
    apb(1'b1, `KWU_IDX_CTRL_LOW, 32'h1);
    apb(1'b1, `KWU_IDX_SYS_CTRL, 32'h3);
    st();
    chk({31'h0, stop_active}, 32'h1);
    key_driven <= 8'hff;
    key_level <= 8'hfe;
    wait_st(st_warm);
    wait_st(st_run);
    chk(32'(n), 32'd40);
    chk({31'h0, irq}, 32'h1);
    rdc(`KWU_IDX_EVT_STAT, 32'h1);
    apb(1'b1, `KWU_IDX_CTRL_LOW, 32'h0);
    apb(1'b1, `KWU_IDX_SYS_CTRL, 32'h1);
    st();
    chk(32'(stop_state), 32'(st_stop));
    pin_level <= 1'b1;
    wait_st(st_warm);
    chk(32'(stop_state), 32'(st_warm));
    wait_st(st_run);
    chk(32'(n), 32'd40);
    conclude();
  end
endmodule
